/* include/bcl_pkg.sv */
// Shared constants, register map and state types of the boot code loader
`default_nettype none

package bcl_pkg;

  // ****************************************
  // Build defaults
  // ****************************************
  localparam logic [15:0] RELEASE_DELAY_DEF   = 16'd1000;
  localparam logic [18:0] COPY_WORD_TOTAL_DEF = 19'd8192;
  localparam logic [15:0] DEST_START_HIGH_DEF = 16'h4000;
  localparam logic [15:0] DEST_START_LOW_DEF  = 16'h0000;
  localparam logic [31:0] SRC_START_DEF       = 32'h0000_0000;
  localparam logic [1:0]  SW_RESET_KIND_DEF   = 2'h0;
  localparam bit          READ_4BYTE_DEF      = 1'b0;
  localparam bit          SYNC_RESET_DEF      = 1'b0;

  // ****************************************
  // Flash timing, in pclk cycles
  // ****************************************
  localparam int          SPI_CLK_RATIO       = 4;
  localparam logic [15:0] SPI_HALF_CYCLES     = 16'(SPI_CLK_RATIO / 2);
  localparam logic [15:0] SS_DESELECT_CYCLES  = 16'h0008;
  localparam logic [15:0] RST_RECOVERY_CYCLES = 16'h0008;

  // ****************************************
  // Flash command bytes and word step
  // ****************************************
  localparam logic [7:0]  CMD_READ3   = 8'h03;
  localparam logic [7:0]  CMD_READ4   = 8'h13;
  localparam logic [7:0]  CMD_RST_EN  = 8'h66;
  localparam logic [7:0]  CMD_RST     = 8'h99;
  localparam logic [7:0]  CMD_RST_ALT = 8'hf0;
  localparam logic [7:0]  CMD_FILL    = 8'h00;
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;

  // ****************************************
  // Status register map
  // ****************************************
  localparam logic [11:0] STATUS_OFFSET     = 12'h000;
  localparam logic [11:0] WORDS_OFFSET      = 12'h004;
  localparam logic [11:0] CTRL_OFFSET       = 12'h008;
  localparam int          ERR_WRITE_BIT     = 0;
  localparam int          ERR_VERIFY_BIT    = 1;
  localparam int          CTRL_HANDOVER_BIT = 0;
  localparam logic        CTRL_HANDOVER_RST = 1'b1;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [2:0] {
    WR_WAIT  = 3'b000,
    WR_WSET  = 3'b001,
    WR_WACC  = 3'b011,
    WR_RSET  = 3'b010,
    WR_RACC  = 3'b110,
    WR_DELAY = 3'b111,
    WR_DONE  = 3'b101,
    WR_FAIL  = 3'b100
  } bcl_wr_state_type;

  typedef enum logic [1:0] {
    RD_WAIT = 2'b00,
    RD_HDR  = 2'b01,
    RD_DATA = 2'b11,
    RD_DONE = 2'b10
  } bcl_rd_state_type;

endpackage

`default_nettype wire

/* rtl/bcl_reset_ctrl.sv */
// Reset controller: merges the boot reset sources into one internal reset
`default_nettype none

module bcl_reset_ctrl #(
  parameter bit SYNC_RESET = bcl_pkg::SYNC_RESET_DEF
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic system_reset_request,
  input  wire logic watchdog_reset_request,
  output logic      arst_n,
  output logic      loader_internal_reset_n
);
  import bcl_pkg::*;

  logic       req;
  logic [1:0] hold_reg;

  // Async flops see the pin only in the async build
  assign arst_n = SYNC_RESET ? 1'b1 : presetn;
  assign req    = system_reset_request | watchdog_reset_request
                | (SYNC_RESET & ~presetn);

  // Two-stage release keeps the internal reset clean of request glitches
  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg <= 2'b00;
    end else if (req) begin
      hold_reg <= 2'b00;
    end else begin
      hold_reg <= {hold_reg[0], 1'b1};
    end
  end

  assign loader_internal_reset_n = hold_reg[1];

endmodule

`default_nettype wire

/* rtl/bcl_spi_byte.sv */
// Mode 0 serial byte engine: one byte out on mosi, one byte in from miso
`default_nettype none

module bcl_spi_byte (
  input  wire logic       pclk,
  input  wire logic       arst_n,
  input  wire logic       srst_n,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       miso,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rx_byte,
  output logic            sck,
  output logic            mosi
);
  import bcl_pkg::*;

  logic [15:0] div_reg;
  logic [3:0]  edge_reg;
  logic [7:0]  shift_reg;
  logic        tick;

  // One enable pulse per half period of the serial clock
  assign tick = busy & (div_reg <= 16'h0001);

  // Clock idles low, data sampled on rising, shifted on falling
  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      {busy, done, sck, mosi} <= 4'h0;
      {div_reg, edge_reg, shift_reg, rx_byte} <= '0;
    end else if (!srst_n) begin
      {busy, done, sck, mosi} <= 4'h0;
      {div_reg, edge_reg, shift_reg, rx_byte} <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy      <= 1'b1;
        div_reg   <= SPI_HALF_CYCLES;
        edge_reg  <= 4'hf;
        shift_reg <= tx_byte;
        mosi      <= tx_byte[7];
        sck       <= 1'b0;
      end else if (busy) begin
        div_reg <= tick ? SPI_HALF_CYCLES : div_reg - 16'h0001;
        if (tick) begin
          sck <= ~sck;
          if (!sck) begin
            rx_byte <= {rx_byte[6:0], miso};
          end else begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            mosi      <= shift_reg[6];
          end
          if (edge_reg == 4'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            edge_reg <= edge_reg - 4'h1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/bcl_top.sv */
// Boot code loader: flash reader, word writer, processor hold and status
//
// Behaviour
// - One clock; active-low external reset plus active-high system reset request.
// - Synchronous reset flops for one build choice, asynchronous otherwise.
// - External reset, system request or watchdog request each start a boot.
// - Reset controller makes the internal reset for reader and writer.
// - During reset hold processor, block its memory access, open loader access.
// - Reader fetches boot bytes one at a time and packs 32-bit words.
// - Writer stores each word into processor memory with bus writes.
// - Writer shows word-ready; on word-valid it writes the presented word.
// - A slave error on any transfer aborts boot and sets error bit 0.
// - After reader completes, first word is read back; mismatch sets error bit 1.
// - After clean check wait release delay, then free processor, swap blocks.
// - After boot the flash pins pass to the peripheral side.
// - Memory side is an APB 3.0 initiator port to the memory target port.
// - Flash reads use mode 0, optional reset command sets, tunable timing.
// - Bypass input high suppresses the whole boot transfer.
// - Release delay is a build parameter, 4 to 65535, default 1000.
// - Word count is a build parameter, 0 to 262144, default 8192.
// - Destination start is two 16-bit halves, defaults 0x4000 and 0x0000.
//
// Implementation choices: the APB register port and the placing of the registers.
`default_nettype none

module bcl_top #(
  parameter bit          SYNC_RESET      = bcl_pkg::SYNC_RESET_DEF,
  parameter logic [15:0] RELEASE_DELAY   = bcl_pkg::RELEASE_DELAY_DEF,
  parameter logic [18:0] COPY_WORD_TOTAL = bcl_pkg::COPY_WORD_TOTAL_DEF,
  parameter logic [15:0] DEST_START_HIGH = bcl_pkg::DEST_START_HIGH_DEF,
  parameter logic [15:0] DEST_START_LOW  = bcl_pkg::DEST_START_LOW_DEF,
  parameter logic [1:0]  SW_RESET_KIND   = bcl_pkg::SW_RESET_KIND_DEF,
  parameter bit          READ_4BYTE      = bcl_pkg::READ_4BYTE_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        system_reset_request,
  input  wire logic        watchdog_reset_request,
  input  wire logic        boot_bypass,
  input  wire logic        s_psel,
  input  wire logic        s_penable,
  input  wire logic        s_pwrite,
  input  wire logic [31:0] s_paddr,
  input  wire logic [31:0] s_pwdata,
  output logic [31:0]      s_prdata,
  output logic             s_pready,
  output logic             s_pslverr,
  output logic [31:0]      m_paddr,
  output logic             m_psel,
  output logic             m_penable,
  output logic             m_pwrite,
  output logic [31:0]      m_pwdata,
  input  wire logic [31:0] m_prdata,
  input  wire logic        m_pready,
  input  wire logic        m_pslverr,
  output logic             processor_hold_n,
  output logic             processor_memory_block,
  output logic             loader_memory_block,
  output logic [1:0]       boot_error,
  output logic             flash_sck,
  output logic             flash_mosi,
  output logic             flash_ss_n,
  input  wire logic        flash_miso,
  input  wire logic        periph_sck,
  input  wire logic        periph_mosi,
  input  wire logic        periph_ss_n,
  output logic             periph_miso
);
  import bcl_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [31:0] DEST_START = {DEST_START_HIGH, DEST_START_LOW};
  localparam logic [2:0]  ADDR_LAST  = READ_4BYTE ? 3'h4 : 3'h3;

  logic             arst_n;
  logic             loader_internal_reset_n;
  bcl_rd_state_type rd_state;
  bcl_wr_state_type wr_state;
  logic [1:0]       cmd_reg;
  logic [2:0]       idx_reg;
  logic [15:0]      wait_reg;
  logic             ss_n_reg;
  logic [1:0]       bcnt_reg;
  logic [18:0]      left_reg;
  logic             reader_word_valid;
  logic [31:0]      word_reg;
  logic [31:0]      first_reg;
  logic             released_reg;
  logic [1:0]       err_reg;
  logic [18:0]      wcount_reg;
  logic [15:0]      dly_reg;
  logic             ctrl_reg;
  logic             eng_busy;
  logic             eng_done;
  logic [7:0]       eng_rx;
  logic             eng_sck;
  logic             eng_mosi;
  logic             eng_start;
  logic [8:0]       hdr;
  logic             word_ready;
  logic             word_take;
  logic             all_done;
  logic [31:0]      next_addr;

  // ****************************************
  // Reset controller and byte engine
  // ****************************************
  bcl_reset_ctrl #(
    .SYNC_RESET (SYNC_RESET)
  ) u_reset (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .system_reset_request    (system_reset_request),
    .watchdog_reset_request  (watchdog_reset_request),
    .arst_n                  (arst_n),
    .loader_internal_reset_n (loader_internal_reset_n)
  );

  bcl_spi_byte u_byte (
    .pclk    (pclk),
    .arst_n  (arst_n),
    .srst_n  (loader_internal_reset_n),
    .start   (eng_start),
    .tx_byte (hdr[7:0]),
    .miso    (flash_miso),
    .busy    (eng_busy),
    .done    (eng_done),
    .rx_byte (eng_rx),
    .sck     (eng_sck),
    .mosi    (eng_mosi)
  );

  // ****************************************
  // Flash command bytes
  // ****************************************
  // Returns {last byte of command, byte}; data phase sends fill bytes
  function automatic logic [8:0] hdr_byte(input logic [1:0] cmd, input logic [2:0] idx,
                                          input logic data_phase);
    logic [2:0]  sh;
    logic [31:0] shifted;
    sh       = ADDR_LAST - idx;
    shifted  = SRC_START_DEF >> {sh, 3'b000};
    hdr_byte = {1'b0, CMD_FILL};
    if (!data_phase) begin
      case (cmd)
        2'h0: begin
          case (SW_RESET_KIND)
            2'h1:    hdr_byte = {1'b1, CMD_RST_EN};
            2'h2:    hdr_byte = {idx == 3'h3, (idx == 3'h0) ? CMD_RST_ALT : CMD_FILL};
            default: hdr_byte = {1'b1, CMD_RST_ALT};
          endcase
        end
        2'h1:    hdr_byte = {1'b1, CMD_RST};
        default: begin
          if (idx == 3'h0) begin
            hdr_byte = {1'b0, READ_4BYTE ? CMD_READ4 : CMD_READ3};
          end else begin
            hdr_byte = {idx == ADDR_LAST, shifted[7:0]};
          end
        end
      endcase
    end
  endfunction

  assign hdr = hdr_byte(cmd_reg, idx_reg, rd_state == RD_DATA);

  // ****************************************
  // Byte reader
  // ****************************************
  // Next byte only when the engine is fully idle; stall while a word waits
  assign eng_start = ~eng_busy & ~eng_done
                   & ((rd_state == RD_HDR)
                   | ((rd_state == RD_DATA) & (left_reg != 19'h0) & ~reader_word_valid));
  assign word_take = reader_word_valid & word_ready;
  assign all_done  = (rd_state == RD_DONE);

  // Reader sequence: recovery wait, optional reset commands, read, stream
  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_state <= RD_WAIT;
      {cmd_reg, idx_reg, bcnt_reg, reader_word_valid} <= '0;
      wait_reg <= RST_RECOVERY_CYCLES;
      ss_n_reg <= 1'b1;
      left_reg <= COPY_WORD_TOTAL;
    end else if (!loader_internal_reset_n) begin
      rd_state          <= RD_WAIT;
      cmd_reg           <= (SW_RESET_KIND == 2'h0) ? 2'h2 : 2'h0;
      {idx_reg, bcnt_reg, reader_word_valid} <= '0;
      wait_reg          <= RST_RECOVERY_CYCLES;
      ss_n_reg          <= 1'b1;
      left_reg          <= COPY_WORD_TOTAL;
    end else begin
      if (word_take) begin
        reader_word_valid <= 1'b0;
      end
      case (rd_state)
        RD_WAIT: begin
          if (boot_bypass) begin
            rd_state <= RD_DONE;
          end else if (wait_reg > 16'h0001) begin
            wait_reg <= wait_reg - 16'h0001;
          end else begin
            rd_state <= RD_HDR;
            ss_n_reg <= 1'b0;
            idx_reg  <= 3'h0;
          end
        end
        RD_HDR: begin
          if (eng_done) begin
            if (!hdr[8]) begin
              idx_reg <= idx_reg + 3'h1;
            end else if (cmd_reg == 2'h2) begin
              rd_state <= RD_DATA;
            end else begin
              // Deselect between commands, recovery after the last reset command
              rd_state <= RD_WAIT;
              ss_n_reg <= 1'b1;
              cmd_reg  <= (cmd_reg == 2'h0 && SW_RESET_KIND == 2'h1) ? 2'h1 : 2'h2;
              wait_reg <= (cmd_reg == 2'h0 && SW_RESET_KIND == 2'h1)
                        ? SS_DESELECT_CYCLES : RST_RECOVERY_CYCLES;
            end
          end
        end
        RD_DATA: begin
          if (eng_done) begin
            bcnt_reg <= bcnt_reg + 2'h1;
            if (bcnt_reg == 2'h3) begin
              reader_word_valid <= 1'b1;
              left_reg          <= left_reg - 19'h1;
            end
          end else if (left_reg == 19'h0 && !reader_word_valid) begin
            rd_state <= RD_DONE;
            ss_n_reg <= 1'b1;
          end
        end
        RD_DONE: begin
          ss_n_reg <= 1'b1;
        end
        default: begin
          rd_state <= RD_DONE;
        end
      endcase
    end
  end

  // Bytes pack low lane first; only read while a word is valid
  always_ff @(posedge pclk) begin
    if (eng_done && rd_state == RD_DATA) begin
      word_reg[{bcnt_reg, 3'b000} +: 8] <= eng_rx;
    end
  end

  // ****************************************
  // Word writer
  // ****************************************
  assign word_ready = (wr_state == WR_WAIT) & ~boot_bypass;
  assign next_addr  = DEST_START + 32'({wcount_reg, 2'b00});
  assign m_psel     = (wr_state == WR_WSET) | (wr_state == WR_WACC)
                    | (wr_state == WR_RSET) | (wr_state == WR_RACC);
  assign m_penable  = (wr_state == WR_WACC) | (wr_state == WR_RACC);

  // Writes, read-back check, release countdown; idle for good afterwards
  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_state     <= WR_WAIT;
      {released_reg, err_reg, wcount_reg, dly_reg, m_pwrite} <= '0;
      {m_paddr, m_pwdata} <= '0;
    end else if (!loader_internal_reset_n) begin
      wr_state     <= WR_WAIT;
      {released_reg, err_reg, wcount_reg, dly_reg, m_pwrite} <= '0;
      {m_paddr, m_pwdata} <= '0;
    end else begin
      case (wr_state)
        WR_WAIT: begin
          if (boot_bypass) begin
            wr_state <= WR_DELAY;
            dly_reg  <= RELEASE_DELAY;
          end else if (reader_word_valid) begin
            wr_state <= WR_WSET;
            m_paddr  <= next_addr;
            m_pwdata <= word_reg;
            m_pwrite <= 1'b1;
          end else if (all_done) begin
            if (wcount_reg == 19'h0) begin
              wr_state <= WR_DELAY;
              dly_reg  <= RELEASE_DELAY;
            end else begin
              wr_state <= WR_RSET;
              m_paddr  <= DEST_START;
              m_pwrite <= 1'b0;
            end
          end
        end
        WR_WSET: begin
          wr_state <= WR_WACC;
        end
        WR_WACC: begin
          if (m_pready) begin
            if (m_pslverr) begin
              err_reg[ERR_WRITE_BIT] <= 1'b1;
              wr_state               <= WR_FAIL;
            end else begin
              wcount_reg <= wcount_reg + 19'h1;
              wr_state   <= WR_WAIT;
            end
          end
        end
        WR_RSET: begin
          wr_state <= WR_RACC;
        end
        WR_RACC: begin
          if (m_pready) begin
            if (m_pslverr) begin
              err_reg[ERR_WRITE_BIT] <= 1'b1;
              wr_state               <= WR_FAIL;
            end else if (m_prdata != first_reg) begin
              err_reg[ERR_VERIFY_BIT] <= 1'b1;
              wr_state                <= WR_FAIL;
            end else begin
              wr_state <= WR_DELAY;
              dly_reg  <= RELEASE_DELAY;
            end
          end
        end
        WR_DELAY: begin
          if (dly_reg <= 16'h0001) begin
            wr_state     <= WR_DONE;
            released_reg <= 1'b1;
          end else begin
            dly_reg <= dly_reg - 16'h0001;
          end
        end
        WR_DONE: begin
          wr_state <= WR_DONE;
        end
        WR_FAIL: begin
          wr_state <= WR_FAIL;
        end
        default: begin
          wr_state <= WR_FAIL;
        end
      endcase
    end
  end

  // First word kept for the read-back compare
  always_ff @(posedge pclk) begin
    if (wr_state == WR_WAIT && reader_word_valid && !boot_bypass && wcount_reg == 19'h0) begin
      first_reg <= word_reg;
    end
  end

  // ****************************************
  // Processor hold and access blocks
  // ****************************************
  assign processor_hold_n       = released_reg;
  assign processor_memory_block = ~released_reg;
  assign loader_memory_block    = released_reg;
  assign boot_error             = err_reg;

  // ****************************************
  // Flash pin handover
  // ****************************************
  // Peripheral side drives flash_sck, flash_mosi and flash_ss_n only after release and while enabled; periph_miso always follows flash_miso
  assign flash_sck   = (released_reg & ctrl_reg) ? periph_sck  : eng_sck;
  assign flash_mosi  = (released_reg & ctrl_reg) ? periph_mosi : eng_mosi;
  assign flash_ss_n  = (released_reg & ctrl_reg) ? periph_ss_n : ss_n_reg;
  assign periph_miso = flash_miso;

  // ****************************************
  // Status register slave
  // ****************************************
  logic        hit_status;
  logic        hit_words;
  logic        hit_ctrl;
  logic        s_hit;
  logic [31:0] rd_mux;

  // Zero-wait slave; unmapped addresses answer with an error
  assign hit_status = (s_paddr[11:0] == STATUS_OFFSET);
  assign hit_words  = (s_paddr[11:0] == WORDS_OFFSET);
  assign hit_ctrl   = (s_paddr[11:0] == CTRL_OFFSET);
  assign s_hit      = hit_status | hit_words | hit_ctrl;
  assign s_pready   = 1'b1;
  assign s_pslverr  = s_psel & s_penable & ~s_hit;
  assign rd_mux     = hit_status ? {28'h0, released_reg,
                                    (wr_state != WR_DONE) & (wr_state != WR_FAIL), err_reg}
                    : hit_words  ? {13'h0, wcount_reg}
                    : hit_ctrl   ? {31'h0, ctrl_reg}
                    : 32'h0;

  // Read data latched in setup; control survives loader resets, not pin reset
  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      s_prdata <= 32'h0;
      ctrl_reg <= CTRL_HANDOVER_RST;
    end else if (SYNC_RESET && !presetn) begin
      s_prdata <= 32'h0;
      ctrl_reg <= CTRL_HANDOVER_RST;
    end else begin
      if (s_psel && !s_penable && !s_pwrite) begin
        s_prdata <= rd_mux;
      end
      if (s_psel && s_penable && s_pwrite && hit_ctrl) begin
        ctrl_reg <= s_pwdata[CTRL_HANDOVER_BIT];
      end
    end
  end

endmodule

`default_nettype wire

/* tb/bcl_mem_model.sv */
// Memory target port model: one stall, stores words, injects faults
`default_nettype none
module bcl_mem_model (
  input  wire logic        pclk,
  input  wire logic        m_psel,
  input  wire logic        m_penable,
  input  wire logic        m_pwrite,
  input  wire logic [31:0] m_paddr,
  input  wire logic [31:0] m_pwdata,
  input  wire logic        err_en,
  input  wire logic        bad_rd,
  input  wire logic        flash_sck,
  input  wire logic        flash_ss_n,
  output logic [31:0]      m_prdata,
  output logic             m_pready,
  output logic             m_pslverr,
  output logic             flash_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:3];
  logic [31:0] last_a;
  int          n_wr = 0, nf = 0;
  wire         acc = m_psel && m_penable;
  // Flash data flips each byte; sck falls counted while selected
  assign flash_miso = nf[3];
  always @(negedge flash_sck or posedge flash_ss_n) nf <= flash_ss_n ? 0 : nf + 1;
  // Answer after one stall; read data toggles when not answering
  always @(posedge pclk) begin
    m_pready <= acc && !m_pready;
    m_pslverr <= acc && !m_pready && err_en;
    m_prdata <= (acc && !m_pready) ? mem[m_paddr[3:2]] ^ {32{bad_rd}} : ~m_prdata;
    if (acc && m_pready && m_pwrite && !m_pslverr) begin
      mem[m_paddr[3:2]] <= m_pwdata;
      last_a <= m_paddr;
      n_wr <= n_wr + 1;
    end
  end
endmodule
`default_nettype wire

/* tb/bcl_sva.sv */
// Port assertions and covers of the boot code loader
`default_nettype none
module bcl_sva #(
  parameter logic [15:0] DEST_START_HIGH = 16'h4000,
  parameter logic [15:0] DEST_START_LOW  = 16'h0000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        system_reset_request,
  input wire logic        watchdog_reset_request,
  input wire logic        m_psel,
  input wire logic        m_penable,
  input wire logic        m_pwrite,
  input wire logic [31:0] m_paddr,
  input wire logic [31:0] m_pwdata,
  input wire logic        m_pready,
  input wire logic        m_pslverr,
  input wire logic        processor_hold_n,
  input wire logic        processor_memory_block,
  input wire logic        loader_memory_block,
  input wire logic [1:0]  boot_error
);
  wire acc = m_psel && m_penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // Hold and block signals
  // ****
  AST_BLOCKS: assert property (processor_memory_block == !processor_hold_n
    && loader_memory_block == processor_hold_n) else $error("block mismatch");
  AST_SYS_REQ: assert property (system_reset_request |-> ##[1:3] !processor_hold_n)
    else $error("system request no hold");
  AST_WDOG_REQ: assert property (watchdog_reset_request |-> ##[1:3] !processor_hold_n)
    else $error("watchdog request no hold");
  AST_ERR_HELD: assert property (boot_error != 2'b00 |-> !processor_hold_n)
    else $error("released with error");
  // Memory bus
  AST_SETUP: assert property ($rose(m_psel) |-> !m_penable ##1 m_penable)
    else $error("no setup phase");
  AST_STABLE: assert property (acc && !m_pready |=> acc && $stable(m_paddr)
    && $stable(m_pwdata) && $stable(m_pwrite)) else $error("request changed");
  AST_SLVERR: assert property (acc && m_pready && m_pslverr |=> boot_error[0] && !m_psel)
    else $error("slave error ignored");
  AST_READBACK: assert property (acc && !m_pwrite
    |-> m_paddr == {DEST_START_HIGH, DEST_START_LOW}) else $error("read-back address");
  AST_IDLE: assert property (processor_hold_n |-> !m_psel) else $error("bus after release");
  COV_REL: cover property ($rose(processor_hold_n));
  COV_WERR: cover property ($rose(boot_error[0]));
  COV_VERR: cover property ($rose(boot_error[1]));
endmodule
bind bcl_top bcl_sva #(.DEST_START_HIGH(DEST_START_HIGH), .DEST_START_LOW(DEST_START_LOW))
  u_sva (.*);
`default_nettype wire

/* tb/test_bcl_top.sv */
// Bench for the boot code loader: boots, restarts, faults, status port
`default_nettype none
module test_bcl_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bcl_pkg::*;
  logic        pclk, presetn, system_reset_request, watchdog_reset_request, boot_bypass;
  logic        s_psel, s_penable, s_pwrite, s_pready, s_pslverr, m_psel, m_penable, e;
  logic        m_pwrite, m_pready, m_pslverr, processor_hold_n, processor_memory_block;
  logic        loader_memory_block, flash_sck, flash_mosi, flash_ss_n, flash_miso;
  logic        periph_sck, periph_mosi, periph_ss_n, periph_miso, err_en, bad_rd;
  logic [1:0]  boot_error;
  logic [31:0] s_paddr, s_pwdata, s_prdata, m_paddr, m_pwdata, m_prdata, d;
  int          n_errors = 0;
  int          checked = 0;
  int          n;
  // Short delay and two words keep each boot to a few hundred cycles
  bcl_top #(.RELEASE_DELAY(16'd4), .COPY_WORD_TOTAL(19'd2)) uut (.*);
  bcl_mem_model u_mem (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (exp !== got) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, output logic [31:0] rd, output logic er);
    @(posedge pclk);
    s_psel <= 1'b1;
    s_pwrite <= wr;
    s_paddr <= {20'h0, a};
    @(posedge pclk);
    s_penable <= 1'b1;
    @(posedge pclk);
    while (s_pready !== 1'b1) @(posedge pclk);
    rd = s_prdata;
    er = s_pslverr;
    s_psel <= 1'b0;
    s_penable <= 1'b0;
  endtask
  // Source 0 external reset, 1 system request, 2 watchdog request
  task automatic restart(int src);
    @(posedge pclk);
    presetn <= (src != 0);
    system_reset_request <= (src == 1);
    watchdog_reset_request <= (src == 2);
    repeat (2) @(posedge pclk);
    {presetn, system_reset_request, watchdog_reset_request} <= 3'b100;
    @(posedge pclk);
    check("hold/blocks", 32'h2, 32'({processor_hold_n, processor_memory_block, loader_memory_block}));
  endtask
  task automatic wait_done();
    for (int i = 0; i < 4000; i++) begin
      @(posedge pclk);
      if (processor_hold_n === 1'b1 || boot_error !== 2'b00) break;
    end
    repeat (20) @(posedge pclk);
  endtask
  task automatic t_boot();
    restart(0);
    wait_done();
    check("released", 32'h3, 32'({processor_hold_n, loader_memory_block}));
    check("word1", 32'hff00_ff00, u_mem.mem[1]);
    check("last addr", 32'h4000_0004, u_mem.last_a);
    check("writes", 32'd2, u_mem.n_wr);
  endtask
  task automatic t_regs();
    apb(1'b0, STATUS_OFFSET, d, e);
    check("status", 32'h8, d);
    apb(1'b1, WORDS_OFFSET, d, e);
    apb(1'b0, WORDS_OFFSET, d, e);
    check("words", 32'd2, d);
    apb(1'b0, 12'h00c, d, e);
    check("unmapped", 32'h1, 32'(e));
  endtask
  task automatic t_restart();
    for (int s = 1; s < 3; s++) begin
      restart(s);
      wait_done();
      check("rebooted", 32'(2 + 2 * s), u_mem.n_wr);
    end
  endtask
  task automatic t_fault(int kind);
    err_en <= (kind == 0);
    bad_rd <= (kind == 1);
    restart(kind + 1);
    wait_done();
    check("error", 32'(1 << kind), 32'(boot_error));
    check("held", 32'h0, 32'(processor_hold_n));
  endtask
  task automatic t_bypass();
    {err_en, bad_rd, boot_bypass} <= 3'b001;
    n = u_mem.n_wr;
    restart(1);
    wait_done();
    check("bypass release", 32'h1, 32'(processor_hold_n));
    check("bypass writes", 32'(n), u_mem.n_wr);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {presetn, system_reset_request, watchdog_reset_request, boot_bypass} = 4'h0;
    {s_psel, s_penable, s_pwrite, err_en, bad_rd, periph_sck, periph_mosi} = 7'h00;
    periph_ss_n = 1'b1;
    s_paddr = 32'h0;
    s_pwdata = 32'h0;
    t_boot();
    t_regs();
    t_restart();
    t_fault(0);
    t_fault(1);
    t_bypass();
    complete_run();
  end
  // Six boots take a few thousand cycles
  initial begin
    repeat (50000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
